// *** dv/compressed_texel_block_decoder_test.sv ***
`timescale 1ns/10ps
`default_nettype none
module compressed_texel_block_decoder_test;
    logic clk;
    logic srst;
    wire req_valid;
    wire [127:0] req_block;
    wire [4:0] req_index;
    wire resp_valid;
    wire [31:0] resp_colour;
    wire resp_unsupported;
    integer mismatches = 0, comparisons = 0, cyc = 0, seed = 32'h61EC, i, p, t, n;
    logic [32:0] exp_q[$];
    integer cyc_q[$];
    logic [127:0] blk;

    compressed_texel_block_decoder dut (.clk(clk), .srst(srst), .req_valid(req_valid),
        .req_block(req_block), .req_index(req_index), .resp_valid(resp_valid),
        .resp_colour(resp_colour), .resp_unsupported(resp_unsupported));
    sampler_model m (.clk(clk), .req_valid(req_valid), .req_block(req_block),
        .req_index(req_index));

    function automatic [7:0] w5(input [4:0] x);
        w5 = {x, x[4:2]};
    endfunction
    function automatic [23:0] rgb(input [127:0] b, input integer k, input six, input lsb);
        reg [14:0] f;
        f = b[64+15*k +: 15];
        rgb = {w5(f[14:10]), six ? {f[9:5], lsb, f[9:8]} : w5(f[9:5]), w5(f[4:0])};
    endfunction
    function automatic [31:0] blend(input [31:0] a, input [31:0] b, input [1:0] s, input half);
        integer ch;
        reg [9:0] x, y;
        blend = (s == 2'h0) ? a : ((half && s == 2'h3) ? 32'h00000000 : b);
        for (ch = 0; ch < 4; ch++) begin
            x = {2'h0, a[8*ch +: 8]};
            y = {2'h0, b[8*ch +: 8]};
            if (s == 2'h1 && half) blend[8*ch +: 8] = 8'((x + y) >> 1);
            else if (s == 2'h1) blend[8*ch +: 8] = 8'((2*x + y + 1) / 3);
            else if (s == 2'h2 && !half) blend[8*ch +: 8] = 8'((x + 2*y + 1) / 3);
        end
    endfunction
    function automatic [32:0] expect_out(input [127:0] b, input [4:0] n);
        reg [1:0] s;
        reg h;
        reg [31:0] c0, c1, c2;
        s = b[2*n +: 2];
        h = n[4];
        if (b[127]) begin
            c0 = {8'hFF, rgb(b, h ? 2 : 0, !b[124], h ? b[33] ^ b[126] : b[1] ^ b[125])};
            c1 = {8'hFF, rgb(b, h ? 3 : 1, 1'b1, h ? b[126] : b[125])};
            expect_out = {1'b0, blend(c0, c1, s, b[124])};
        end else if (b[126:125] == 2'h3) begin
            c0 = {w5(b[113:109]), rgb(b, 0, 1'b0, 1'b0)};
            c1 = {w5(b[118:114]), rgb(b, 1, 1'b0, 1'b0)};
            c2 = {w5(b[123:119]), rgb(b, 2, 1'b0, 1'b0)};
            if (b[124]) expect_out = {1'b0, blend(h ? c2 : c0, c1, s, 1'b0)};
            else expect_out = {1'b0, s == 2'h0 ? c0 : s == 2'h1 ? c1 : s == 2'h2 ? c2 : 32'h0};
        end else expect_out = {1'b1, 32'h00000000};
    endfunction

    task check(input [63:0] seen, input [63:0] want);
        comparisons++;
        if (seen !== want) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task end_of_test();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task req(input [127:0] b, input [4:0] x);
        m.send(b, x);
        exp_q.push_back(expect_out(b, x));
        cyc_q.push_back(cyc);
    endtask
    task drain(input string name);
        m.idle();
        repeat (4) @(negedge clk);
        check(exp_q.size(), 0);
        $display("test %s done", name);
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    always @(negedge clk) if (!srst && resp_valid === 1'b1) begin
        if (exp_q.size() == 0) check(1, 0);
        else begin
            check(cyc - cyc_q.pop_front(), 2);
            check({resp_unsupported, resp_colour}, exp_q.pop_front());
        end
    end
    initial begin
        #400000;
        mismatches++;
        end_of_test();
    end
    initial begin
        srst = 1'b1;
        repeat (3) @(negedge clk);
        srst = 1'b0;
        for (p = 0; p < 3; p++) for (t = 0; t < 16; t++) for (n = 0; n < 32; n++) begin
            blk = {$random(seed), $random(seed), $random(seed), $random(seed)};
            if (p < 2) blk = p ? ~128'h0 : 128'h0;
            blk[127:124] = 4'(t);
            req(blk, 5'(n));
        end
        drain("corners");
        for (i = 0; i < 400; i++) begin
            req({$random(seed), $random(seed), $random(seed), $random(seed)}, 5'($random(seed)));
            if (($random(seed) & 3) == 0) m.idle();
        end
        drain("random");
        req({4{$random(seed)}}, 5'($random(seed)));
        // reset lands while that request is still in the pipe, so it must never answer
        m.idle();
        srst = 1'b1;
        exp_q.delete();
        cyc_q.delete();
        @(negedge clk);
        check({resp_valid, resp_colour, resp_unsupported}, 0);
        srst = 1'b0;
        req({4{$random(seed)}}, 5'h1F);
        drain("reset");
        end_of_test();
    end
endmodule // compressed_texel_block_decoder_test

bind compressed_texel_block_decoder texel_decoder_properties chk (.clk(clk), .srst(srst),
    .req_valid(req_valid), .req_block(req_block), .req_index(req_index),
    .resp_valid(resp_valid), .resp_colour(resp_colour), .resp_unsupported(resp_unsupported));
`default_nettype wire

// *** dv/sampler_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module sampler_model (
    input wire logic clk,
    output logic req_valid,
    output logic [127:0] req_block,
    output logic [4:0] req_index
);
    initial begin
        req_valid = 1'b0;
        req_block = 128'h0;
        req_index = 5'h0;
    end
    task send(input [127:0] b, input [4:0] n);
        @(negedge clk);
        req_valid = 1'b1;
        req_block = b;
        req_index = n;
    endtask
    // idle lines show junk, so a stale block can never pass for a request
    task idle();
        @(negedge clk);
        req_valid = 1'b0;
        req_block = ~req_block;
        req_index = ~req_index;
    endtask
endmodule // sampler_model
`default_nettype wire

// *** dv/texel_decoder_properties.sv ***
`timescale 1ns/10ps
`default_nettype none
module texel_decoder_properties (
    input wire logic clk,
    input wire logic srst,
    input wire logic req_valid,
    input wire logic [127:0] req_block,
    input wire logic [4:0] req_index,
    input wire logic resp_valid,
    input wire logic [31:0] resp_colour,
    input wire logic resp_unsupported
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    wire [1:0] sel = req_block[2*req_index +: 2];
    wire mixed = req_valid && req_block[127];
    wire alpha = req_valid && (req_block[127:125] == 3'h3);
    wire [7:0] red0 = {req_block[78:74], req_block[78:76]};
    wire [31:0] alpha_c0 = {req_block[113:109], req_block[113:111], red0,
        req_block[73:69], req_block[73:71], req_block[68:64], req_block[68:66]};

    latency_two_a: assert property (req_valid |-> ##2 resp_valid)
        else $error("response missing two cycles after request");
    no_orphan_a: assert property (resp_valid |-> $past(req_valid, 2))
        else $error("response without request");
    reset_quiet_a: assert property ($fell(srst) |=> !resp_valid)
        else $error("response straight after reset");
    mixed_opaque_a: assert property (mixed && !req_block[124] |-> ##2
        resp_colour[31:24] == 8'hFF && !resp_unsupported) else $error("mixed alpha wrong");
    mixed_transp_a: assert property (mixed && req_block[124] && sel == 2'h3
        |-> ##2 resp_colour == 32'h00000000) else $error("mixed code 3 not black");
    alpha_black_a: assert property (alpha && !req_block[124] && sel == 2'h3
        |-> ##2 resp_colour == 32'h00000000) else $error("alpha code 3 not black");
    alpha_entry0_a: assert property (alpha && sel == 2'h0
        && !(req_block[124] && req_index[4]) |-> ##2 resp_colour == $past(alpha_c0, 2))
        else $error("alpha colour 0 wrong");
    mixed_red0_a: assert property (mixed && sel == 2'h0 && !req_index[4]
        |-> ##2 resp_colour[23:16] == $past(red0, 2)) else $error("mixed red widening wrong");
    unsupported_a: assert property (req_valid && !req_block[127]
        && req_block[126:125] != 2'h3 |-> ##2 resp_unsupported && resp_colour == 32'h00000000)
        else $error("undecoded kind not flagged");

    cover property (mixed && req_block[124] ##2 resp_valid);
    cover property (alpha && req_block[124] && req_index[4]);
    cover property (req_valid [*8]);
endmodule // texel_decoder_properties
`default_nettype wire

// *** src/compressed_texel_block_decoder.v ***
`timescale 1ns/10ps
`default_nettype none
`include "texel_decoder_defs.vh"

// Function
// RL1 - top bit set means mixed-colour kind
// RL2 - mixed: colours 0,1 low half, 2,3 high
// RL3 - texel n selector from bits 2n+1:2n
// RL4 - mixed bit 124 selects transparency variant
// RL5 - flag clear: green lsbs via xor rule
// RL6 - flag clear: green is g5, lsb, g5[4:3]
// RL7 - widen 5 bits by repeating top three
// RL8 - flag clear: thirds table, alpha opaque
// RL9 - flag set: colours 0,2 plain, 1,3 direct lsb
// RL10 - flag set: average table, entry 3 transparent
// RL11 - selector indexes own half table, 32-bit argb
// RL12 - top bits 011 mean alpha-colour kind
// RL13 - alpha kind bit 124 is interpolation flag
// RL14 - alpha kind: three argb colours parsed
// RL15 - alpha kind channels widened by replication
// RL16 - no interpolation: shared table, black entry 3
// RL17 - interpolation: two thirds tables toward colour 1
// RL18 - one request per clock, fixed two-cycle latency
module compressed_texel_block_decoder (
    input wire clk,
    input wire srst,
    input wire req_valid,
    input wire [127:0] req_block,
    input wire [4:0] req_index,
    output reg resp_valid,
    output reg [31:0] resp_colour,
    output reg resp_unsupported
);

    // 5-bit field at any bit position of the block
    function [4:0] field5;
        input [127:0] blk;
        input [6:0] pos;
        begin
            field5 = blk[pos +: 5];
        end
    endfunction

    // high-order replication widening
    function [7:0] expand5;
        input [4:0] v;
        begin
            expand5 = {v, v[4:2]}; // RL7 RL15
        end
    endfunction

    // six-bit green: stored five, recovered lsb, top two repeated
    function [7:0] expand6;
        input [4:0] g;
        input lsb;
        begin
            expand6 = {g, lsb, g[4:3]}; // RL6
        end
    endfunction

    // opaque rgb colour at a field base, green given already widened
    function [31:0] rgb_colour;
        input [127:0] blk;
        input [6:0] base;
        input [7:0] green;
        reg [6:0] rpos;
        reg [6:0] bpos;
        begin
            rpos = base + `CH_RED_OFS;
            bpos = base + `CH_BLUE_OFS;
            rgb_colour = {`ALPHA_OPAQUE, expand5(field5(blk, rpos)), green,
                          expand5(field5(blk, bpos))}; // RL8
        end
    endfunction

    // stored green field of a colour
    function [4:0] green5;
        input [127:0] blk;
        input [6:0] base;
        reg [6:0] gpos;
        begin
            gpos = base + `CH_GREEN_OFS;
            green5 = field5(blk, gpos);
        end
    endfunction

    // argb colour of the alpha kind, all four channels widened
    function [31:0] argb_colour;
        input [127:0] blk;
        input [6:0] base;
        input [6:0] apos;
        reg [6:0] rpos;
        reg [6:0] gpos;
        reg [6:0] bpos;
        begin
            rpos = base + `CH_RED_OFS;
            gpos = base + `CH_GREEN_OFS;
            bpos = base + `CH_BLUE_OFS;
            argb_colour = {expand5(field5(blk, apos)), expand5(field5(blk, rpos)),
                           expand5(field5(blk, gpos)), expand5(field5(blk, bpos))}; // RL14 RL15
        end
    endfunction

    // one-hot kind; the mixed kind wins whatever its two lower mode bits hold
    function [2:0] block_kind;
        input [127:0] blk;
        begin
            if (blk[`KIND_MIXED_BIT]) begin
                block_kind = `KIND_IS_MIXED; // RL1
            end else if (blk[`KIND_TOP_HI:`KIND_TOP_LO] == `KIND_ALPHA_CODE) begin
                block_kind = `KIND_IS_ALPHA; // RL12
            end else begin
                block_kind = `KIND_IS_OTHER;
            end
        end
    endfunction

    // green of colours 0 and 2: plain five bits once transparency is selected
    function [7:0] even_green;
        input transp;
        input [4:0] g;
        input lsb;
        begin
            if (transp) begin
                even_green = expand5(g); // RL9
            end else begin
                even_green = expand6(g, lsb); // RL6
            end
        end
    endfunction

    // shared-table entry of the alpha kind; code 3 is zeroed in the second stage
    function [31:0] direct_pick;
        input [1:0] code;
        input [31:0] c0;
        input [31:0] c1;
        input [31:0] c2;
        begin
            case (code)
                `SEL_0: direct_pick = c0; // RL16
                `SEL_1: direct_pick = c1; // RL16
                default: direct_pick = c2; // RL16
            endcase
        end
    endfunction

    // end colour of the half that the texel lies in
    function [31:0] half_pick;
        input upper;
        input [31:0] low_colour;
        input [31:0] high_colour;
        begin
            if (upper) begin
                half_pick = high_colour; // RL2
            end else begin
                half_pick = low_colour; // RL2
            end
        end
    endfunction

    localparam [6:0] C0_POS = `COL0_BASE;
    localparam [6:0] C1_POS = `COL1_BASE;
    localparam [6:0] C2_POS = `COL2_BASE;
    localparam [6:0] C3_POS = `COL3_BASE;
    localparam [6:0] A0_POS = `ALPHA0_BASE;
    localparam [6:0] A1_POS = `ALPHA1_BASE;
    localparam [6:0] A2_POS = `ALPHA2_BASE;

    // first stage: kind decode, base colours, selector
    wire [2:0] kind;
    wire flag;
    wire upper_half;
    wire [1:0] texel_sel;
    wire [6:0] sel_pos;

    assign kind = block_kind(req_block); // RL1 RL12
    assign flag = req_block[`FLAG_BIT]; // RL4 RL13
    assign upper_half = req_index[`HALF_BIT]; // RL2 RL11
    assign sel_pos = {1'b0, req_index, 1'b0};
    assign texel_sel = req_block[sel_pos +: 2]; // RL3

    // green lsb recovery of the mixed kind
    wire lsb3;
    wire lsb1;
    wire lsb2;
    wire lsb0;
    assign lsb3 = req_block[`MIX_G3_LSB_BIT]; // RL5 RL9
    assign lsb1 = req_block[`MIX_G1_LSB_BIT]; // RL5 RL9
    assign lsb2 = req_block[`MIX_G2_XOR_BIT] ^ req_block[`MIX_G3_LSB_BIT]; // RL5
    assign lsb0 = req_block[`MIX_G0_XOR_BIT] ^ req_block[`MIX_G1_LSB_BIT]; // RL5

    wire [4:0] g0;
    wire [4:0] g1;
    wire [4:0] g2;
    wire [4:0] g3;
    assign g0 = green5(req_block, C0_POS);
    assign g1 = green5(req_block, C1_POS);
    assign g2 = green5(req_block, C2_POS);
    assign g3 = green5(req_block, C3_POS);

    // colours 0 and 2 lose their recovered lsb when transparency is selected
    wire [7:0] mix_g0;
    wire [7:0] mix_g2;
    assign mix_g0 = even_green(flag, g0, lsb0); // RL9 RL6
    assign mix_g2 = even_green(flag, g2, lsb2); // RL9 RL6

    wire [31:0] mix_c0;
    wire [31:0] mix_c1;
    wire [31:0] mix_c2;
    wire [31:0] mix_c3;
    assign mix_c0 = rgb_colour(req_block, C0_POS, mix_g0);
    assign mix_c1 = rgb_colour(req_block, C1_POS, expand6(g1, lsb1)); // RL6 RL9
    assign mix_c2 = rgb_colour(req_block, C2_POS, mix_g2);
    assign mix_c3 = rgb_colour(req_block, C3_POS, expand6(g3, lsb3)); // RL6 RL9

    wire [31:0] alp_c0;
    wire [31:0] alp_c1;
    wire [31:0] alp_c2;
    assign alp_c0 = argb_colour(req_block, C0_POS, A0_POS); // RL14
    assign alp_c1 = argb_colour(req_block, C1_POS, A1_POS); // RL14
    assign alp_c2 = argb_colour(req_block, C2_POS, A2_POS); // RL14

    reg [31:0] end_a_next;
    reg [31:0] end_b_next;
    reg [1:0] sel_next;
    reg [2:0] mode_next;
    reg unsup_next;

    always @* begin
        end_a_next = `COLOUR_ZERO;
        end_b_next = `COLOUR_ZERO;
        sel_next = texel_sel;
        mode_next = `TBL_DIRECT;
        unsup_next = 1'b0;
        case (kind)
            `KIND_IS_MIXED: begin
                // each half has its own pair of end colours
                end_a_next = half_pick(upper_half, mix_c0, mix_c2); // RL2 RL11
                end_b_next = half_pick(upper_half, mix_c1, mix_c3); // RL2 RL11
                mode_next = flag ? `TBL_HALF : `TBL_THIRDS; // RL4 RL8 RL10
            end
            `KIND_IS_ALPHA: begin
                if (flag) begin
                    end_a_next = half_pick(upper_half, alp_c0, alp_c2); // RL17
                    end_b_next = alp_c1; // RL17
                    mode_next = `TBL_THIRDS; // RL17
                end else begin
                    // one shared table; pick the entry here, blend only zeroes code 3
                    end_a_next = direct_pick(texel_sel, alp_c0, alp_c1, alp_c2); // RL16
                    mode_next = `TBL_DIRECT; // RL16
                end
            end
            default: begin
                // high-colour and chroma kinds are not decoded here: answer black
                sel_next = `SEL_3;
                mode_next = `TBL_DIRECT;
                unsup_next = 1'b1;
            end
        endcase
    end

    reg stage_valid_reg;
    reg [31:0] stage_a_reg;
    reg [31:0] stage_b_reg;
    reg [1:0] stage_sel_reg;
    reg [2:0] stage_mode_reg;
    reg stage_unsup_reg;

    // no stall path: the sampler gets one answer per request, two edges later
    always @(posedge clk) begin
        if (srst) begin
            stage_valid_reg <= 1'b0;
            stage_a_reg <= `COLOUR_ZERO;
            stage_b_reg <= `COLOUR_ZERO;
            stage_sel_reg <= `SEL_0;
            stage_mode_reg <= `TBL_DIRECT;
            stage_unsup_reg <= 1'b0;
        end else begin
            stage_valid_reg <= req_valid; // RL18
            stage_a_reg <= end_a_next;
            stage_b_reg <= end_b_next;
            stage_sel_reg <= sel_next;
            stage_mode_reg <= mode_next;
            stage_unsup_reg <= unsup_next;
        end
    end

    // second stage: table entry from the two end colours
    wire [31:0] blended;

    palette_blend u_blend (
        .end_a(stage_a_reg),
        .end_b(stage_b_reg),
        .sel(stage_sel_reg),
        .mode(stage_mode_reg),
        .colour(blended)
    );

    always @(posedge clk) begin
        if (srst) begin
            resp_valid <= 1'b0;
            resp_colour <= `COLOUR_ZERO;
            resp_unsupported <= 1'b0;
        end else begin
            resp_valid <= stage_valid_reg; // RL18
            resp_colour <= blended; // RL11
            resp_unsupported <= stage_unsup_reg;
        end
    end

endmodule // compressed_texel_block_decoder
`default_nettype wire

// *** src/palette_blend.v ***
`timescale 1ns/10ps
`default_nettype none
`include "texel_decoder_defs.vh"

module palette_blend (
    input wire [31:0] end_a,
    input wire [31:0] end_b,
    input wire [1:0] sel,
    input wire [2:0] mode,
    output reg [31:0] colour
);

    // rounded thirds step: (2*near + far + 1) / 3 on one channel
    function [7:0] third;
        input [7:0] near;
        input [7:0] far;
        reg [9:0] sum;
        reg [9:0] quo;
        begin
            sum = {1'b0, near, 1'b0} + {2'b00, far} + 10'h001;
            quo = sum / 10'h003;
            third = quo[7:0];
        end
    endfunction

    // truncating average on one channel
    function [7:0] half;
        input [7:0] x;
        input [7:0] y;
        reg [8:0] sum;
        begin
            sum = {1'b0, x} + {1'b0, y};
            half = sum[8:1];
        end
    endfunction

    reg [31:0] thirds_ab;
    reg [31:0] thirds_ba;
    reg [31:0] avg;
    integer ch;

    always @* begin
        thirds_ab = `COLOUR_ZERO;
        thirds_ba = `COLOUR_ZERO;
        avg = `COLOUR_ZERO;
        for (ch = 0; ch < 4; ch = ch + 1) begin
            thirds_ab[ch*8 +: 8] = third(end_a[ch*8 +: 8], end_b[ch*8 +: 8]); // RL8 RL17
            thirds_ba[ch*8 +: 8] = third(end_b[ch*8 +: 8], end_a[ch*8 +: 8]); // RL8 RL17
            avg[ch*8 +: 8] = half(end_a[ch*8 +: 8], end_b[ch*8 +: 8]); // RL10
        end
    end

    always @* begin
        colour = `COLOUR_ZERO;
        case (mode)
            `TBL_THIRDS: begin
                case (sel)
                    `SEL_0: colour = end_a;
                    `SEL_1: colour = thirds_ab;
                    `SEL_2: colour = thirds_ba;
                    default: colour = end_b;
                endcase
            end
            `TBL_HALF: begin
                case (sel)
                    `SEL_0: colour = end_a;
                    `SEL_1: colour = avg;
                    `SEL_2: colour = end_b;
                    default: colour = `COLOUR_ZERO; // RL10
                endcase
            end
            `TBL_DIRECT: begin
                // entry already chosen upstream; code 3 is transparent black
                if (sel == `SEL_3) begin
                    colour = `COLOUR_ZERO; // RL16
                end else begin
                    colour = end_a;
                end
            end
            default: colour = `COLOUR_ZERO;
        endcase
    end

endmodule // palette_blend
`default_nettype wire

// *** src/texel_decoder_defs.vh ***
`ifndef TEXEL_DECODER_DEFS_VH
`define TEXEL_DECODER_DEFS_VH

// block kind decode
`define KIND_MIXED_BIT 127
`define KIND_TOP_HI 127
`define KIND_TOP_LO 125
`define KIND_ALPHA_CODE 3'h3

// one-hot block kinds
`define KIND_IS_MIXED 3'h1
`define KIND_IS_ALPHA 3'h2
`define KIND_IS_OTHER 3'h4

// shared flag bit: transparency select (mixed) or interpolation flag (alpha)
`define FLAG_BIT 124

// green lsb sources of the mixed-colour kind
`define MIX_G3_LSB_BIT 126
`define MIX_G1_LSB_BIT 125
`define MIX_G2_XOR_BIT 33
`define MIX_G0_XOR_BIT 1

// low bit of each 15-bit rgb colour field
`define COL3_BASE 7'h6D
`define COL2_BASE 7'h5E
`define COL1_BASE 7'h4F
`define COL0_BASE 7'h40

// channel offsets inside a 15-bit colour field, sized to the bit-position width
`define CH_RED_OFS 7'h0A
`define CH_GREEN_OFS 7'h05
`define CH_BLUE_OFS 7'h00

// low bit of each 5-bit alpha field of the alpha-colour kind
`define ALPHA2_BASE 7'h77
`define ALPHA1_BASE 7'h72
`define ALPHA0_BASE 7'h6D

// texel index: top bit selects the block half
`define HALF_BIT 4

// constant channel values
`define ALPHA_OPAQUE 8'hFF
`define COLOUR_ZERO 32'h00000000

// table-building modes, one-hot
`define TBL_THIRDS 3'h1
`define TBL_HALF 3'h2
`define TBL_DIRECT 3'h4

// selector codes
`define SEL_0 2'h0
`define SEL_1 2'h1
`define SEL_2 2'h2
`define SEL_3 2'h3

`endif
